// ===== src/brs_brake_release_sequencer.sv
// brs_brake_release_sequencer: brake release sequencing, feedback check, registers
//
// Function
// - mode 1: run and gate held on-delay
// - mode 2 also needs current at or over threshold
// - stop speed plus off-delay drops release
// - output shutdown drops release
// - on-delay 0.00 to 10.00 s
// - off-delay 0.00 to 100.00 s
// - drop during run locks out until run off
// - confirm mismatch after window trips alarm
// - mismatch tolerated while window runs
// - check only when both terminals assigned
// - output terminal code 57 carries release
// - input terminal code 65 is confirm
// - contactor check shares the window setting
// - contactor mismatch tolerated until window expires
`timescale 1ns/1ns
`default_nettype none
module brs_brake_release_sequencer
   import brs_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES   // shorten for simulation
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire brs_drive_s drive,
   input wire logic [1:0] termIn,
   output logic [1:0] termOut,
   output logic brakeReleaseOut,
   output logic brakeMismatchAlarm,
   output logic contactorMismatchAlarm,
   output logic irq,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      brs_rel_e rel;                 // release sequence state
      logic brkAlarm;                // latched brake mismatch trip
      logic mcAlarm;                 // latched contactor mismatch trip
      logic [1:0] mode;              // release_mode_select
      logic [7:0] pct;               // current_threshold_pct
      logic [ON_W-1:0] onDly;        // release_on_delay
      logic [OFF_W-1:0] offDly;      // release_off_delay
      logic [WIN_W-1:0] win;         // feedback_check_window
      logic [31:0] termSel;          // out0, out1, in0, in1 selectors
      logic [IRQ_W-1:0] irqStat;     // sticky events
      logic [IRQ_W-1:0] irqEn;       // event enables
      logic [TICK_W-1:0] tickCnt;    // prescaler
      logic tick;                    // one pulse per 0.01 s
      logic ack;                     // bus acknowledge
      logic [31:0] rdat;             // read data
      logic [1:0] termOut;           // routed output terminals
   } brs_state_s;

   brs_state_s s_r;
   brs_state_s s_nxt;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // true when either of two selectors holds the code
   function automatic logic selHit(input logic [7:0] a, input logic [7:0] b, input logic [7:0] code);
      selHit = (a == code) || (b == code);
   endfunction

   // merge write data into a register under byte enables
   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            m[8*i +: 8] = wd[8*i +: 8];
         end
      end
      laneMerge = m;
   endfunction

   // ----------------------------------------------------------------
   // combinational terms
   // ----------------------------------------------------------------
   logic [7:0] selOut0;
   logic [7:0] selOut1;
   logic [7:0] selIn0;
   logic [7:0] selIn1;
   logic brakeOutAssigned;      // some output carries release
   logic brakeInAssigned;       // some input carries confirm
   logic mcOutAssigned;
   logic mcInAssigned;
   logic brakeConfirm;          // brake_confirm_in
   logic mcConfirm;             // contactor_confirm_in
   logic [24:0] curScaled;      // output current times 100
   logic [24:0] curLimit;       // no-load current times percent
   logic curOk;
   logic onArm;
   logic onDone;
   logic offArm;
   logic offDone;
   logic shutdown;
   logic brkFault;
   logic mcFault;
   logic relNow;
   logic relNxt;
   logic wbReq;

   assign selOut0 = s_r.termSel[7:0];
   assign selOut1 = s_r.termSel[15:8];
   assign selIn0 = s_r.termSel[23:16];
   assign selIn1 = s_r.termSel[31:24];
   assign brakeOutAssigned = selHit(selOut0, selOut1, FN_BRAKE_OUT);
   assign brakeInAssigned = selHit(selIn0, selIn1, FN_BRAKE_IN);
   assign mcOutAssigned = selHit(selOut0, selOut1, FN_MC_OUT);
   assign mcInAssigned = selHit(selIn0, selIn1, FN_MC_IN);
   assign brakeConfirm = (selIn0 == FN_BRAKE_IN) ? termIn[0] : termIn[1];
   assign mcConfirm = (selIn0 == FN_MC_IN) ? termIn[0] : termIn[1];

   // current test: cur*100 >= noLoad*pct
   assign curScaled = 25'(drive.outputCurrent) * 25'd100;
   assign curLimit = 25'(drive.noLoadCurrent) * 25'(s_r.pct);
   assign curOk = (s_r.mode != MODE_CURRENT) || (curScaled >= curLimit);

   // on-delay armed while run, gate (and current) held continuously
   assign onArm = (s_r.rel == ST_APPLIED) && drive.runCmd && drive.outputGate && curOk;
   assign offArm = (s_r.rel == ST_OFF_WAIT);
   assign shutdown = drive.outputShutdown || s_r.brkAlarm;
   assign relNow = (s_r.rel == ST_RELEASED) || (s_r.rel == ST_OFF_WAIT);
   assign wbReq = wb_cyc_i && wb_stb_i && !s_r.ack;

   // ----------------------------------------------------------------
   // timers and checkers
   // ----------------------------------------------------------------
   brs_delay #(.W(ON_W)) u_onDelay (
      .mclk(mclk),
      .rst_b(rst_b),
      .tick(s_r.tick),
      .arm(onArm),
      .limit(s_r.onDly),
      .done(onDone)
   );

   brs_delay #(.W(OFF_W)) u_offDelay (
      .mclk(mclk),
      .rst_b(rst_b),
      .tick(s_r.tick),
      .arm(offArm),
      .limit(s_r.offDly),
      .done(offDone)
   );

   // brake output against its confirmation
   brs_check u_brakeCheck (
      .mclk(mclk),
      .rst_b(rst_b),
      .tick(s_r.tick),
      .enable(brakeOutAssigned && brakeInAssigned),
      .cmd(relNow),
      .fb(brakeConfirm),
      .window(s_r.win),
      .fault(brkFault)
   );

   // contactor control against its confirmation, same window
   brs_check u_mcCheck (
      .mclk(mclk),
      .rst_b(rst_b),
      .tick(s_r.tick),
      .enable(mcOutAssigned && mcInAssigned),
      .cmd(drive.contactorCtrlOut),
      .fb(mcConfirm),
      .window(s_r.win),
      .fault(mcFault)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      // prescaler for the 0.01 s unit
      s_nxt.tick = 1'b0;
      if (s_r.tickCnt >= TICK_W'(TICK_CYC - 1)) begin
         s_nxt.tickCnt = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.tickCnt = s_r.tickCnt + 1'b1;
      end

      // release sequence
      case (s_r.rel)
         ST_APPLIED: begin
            if (onDone && !shutdown) begin
               s_nxt.rel = ST_RELEASED;
            end
         end
         ST_RELEASED: begin
            if (shutdown) begin
               s_nxt.rel = drive.runCmd ? ST_LOCKED : ST_APPLIED;
            end else if (drive.belowStopSpeed) begin
               s_nxt.rel = ST_OFF_WAIT;
            end
         end
         ST_OFF_WAIT: begin
            // run command plays no part in the off decision
            if (shutdown || offDone) begin
               s_nxt.rel = drive.runCmd ? ST_LOCKED : ST_APPLIED;
            end
         end
         ST_LOCKED: begin
            if (!drive.runCmd) begin
               s_nxt.rel = ST_APPLIED;
            end
         end
         default: begin
            s_nxt.rel = ST_APPLIED;
         end
      endcase
      relNxt = (s_nxt.rel == ST_RELEASED) || (s_nxt.rel == ST_OFF_WAIT);

      // terminal routing, one selector per output
      for (int i = 0; i < 2; i++) begin
         if (s_r.termSel[8*i +: 8] == FN_BRAKE_OUT) begin
            s_nxt.termOut[i] = relNxt;
         end else if (s_r.termSel[8*i +: 8] == FN_MC_OUT) begin
            s_nxt.termOut[i] = drive.contactorCtrlOut;
         end else begin
            s_nxt.termOut[i] = 1'b0;
         end
      end

      // bus: one wait state, then ack for one cycle
      s_nxt.ack = wbReq;
      s_nxt.rdat = '0;
      if (wbReq && wb_we_i) begin
         case (wb_adr_i)
            OFS_CTRL: begin
               if (wb_sel_i[0]) begin
                  s_nxt.mode = wb_dat_i[1:0];
               end
            end
            OFS_THRESH: begin
               if (wb_sel_i[0]) begin
                  s_nxt.pct = (wb_dat_i[7:0] > PCT_MAX) ? PCT_MAX : wb_dat_i[7:0];
               end
            end
            OFS_ONDLY: begin
               s_nxt.onDly = ON_W'(laneMerge(32'(s_r.onDly), wb_dat_i, wb_sel_i));
               if (s_nxt.onDly > ON_MAX) begin
                  s_nxt.onDly = ON_MAX;
               end
            end
            OFS_OFFDLY: begin
               s_nxt.offDly = OFF_W'(laneMerge(32'(s_r.offDly), wb_dat_i, wb_sel_i));
               if (s_nxt.offDly > OFF_MAX) begin
                  s_nxt.offDly = OFF_MAX;
               end
            end
            OFS_CHKWIN: begin
               s_nxt.win = WIN_W'(laneMerge(32'(s_r.win), wb_dat_i, wb_sel_i));
               if (s_nxt.win > WIN_MAX) begin
                  s_nxt.win = WIN_MAX;
               end
            end
            OFS_TERMSEL: begin
               s_nxt.termSel = laneMerge(s_r.termSel, wb_dat_i, wb_sel_i);
            end
            OFS_IRQCLR: begin
               if (wb_sel_i[0]) begin
                  s_nxt.irqStat = s_r.irqStat & ~wb_dat_i[IRQ_W-1:0];
               end
            end
            OFS_IRQEN: begin
               if (wb_sel_i[0]) begin
                  s_nxt.irqEn = wb_dat_i[IRQ_W-1:0];
               end
            end
            default: begin
               // unmapped or read-only: write ignored
            end
         endcase
      end else if (wbReq) begin
         case (wb_adr_i)
            OFS_CTRL: s_nxt.rdat = {30'h0, s_r.mode};
            OFS_THRESH: s_nxt.rdat = {24'h0, s_r.pct};
            OFS_ONDLY: s_nxt.rdat = 32'(s_r.onDly);
            OFS_OFFDLY: s_nxt.rdat = 32'(s_r.offDly);
            OFS_CHKWIN: s_nxt.rdat = 32'(s_r.win);
            OFS_TERMSEL: s_nxt.rdat = s_r.termSel;
            OFS_STATUS: s_nxt.rdat = {24'h0, brakeConfirm, mcConfirm, s_r.mcAlarm, s_r.brkAlarm,
                                      s_r.rel == ST_LOCKED, relNow, s_r.rel};
            OFS_IRQSTAT: s_nxt.rdat = 32'(s_r.irqStat);
            OFS_IRQEN: s_nxt.rdat = 32'(s_r.irqEn);
            default: s_nxt.rdat = '0;
         endcase
      end

      // alarm reset strobe, then trips set (a trip wins the same cycle)
      if (wbReq && wb_we_i && (wb_adr_i == OFS_CTRL) && wb_sel_i[1] && wb_dat_i[CTRL_ALMRST_BIT]) begin
         s_nxt.brkAlarm = 1'b0;
         s_nxt.mcAlarm = 1'b0;
      end
      if (brkFault) begin
         s_nxt.brkAlarm = 1'b1;
      end
      if (mcFault) begin
         s_nxt.mcAlarm = 1'b1;
      end

      // sticky events, set wins over a clear in the same cycle
      if (brkFault && !s_r.brkAlarm) begin
         s_nxt.irqStat[IRQ_BRK_TRIP] = 1'b1;
      end
      if (mcFault && !s_r.mcAlarm) begin
         s_nxt.irqStat[IRQ_MC_TRIP] = 1'b1;
      end
      if (relNxt && !relNow) begin
         s_nxt.irqStat[IRQ_REL_ON] = 1'b1;
      end
      if (!relNxt && relNow) begin
         s_nxt.irqStat[IRQ_REL_OFF] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
         s_r.rel <= ST_APPLIED;
         s_r.mode <= MODE_RST;
         s_r.pct <= PCT_RST;
         s_r.onDly <= ONDLY_RST;
         s_r.offDly <= OFFDLY_RST;
         s_r.win <= CHKWIN_RST;
         s_r.termSel <= TERMSEL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign brakeReleaseOut = relNow;
   assign termOut = s_r.termOut;
   assign brakeMismatchAlarm = s_r.brkAlarm;
   assign contactorMismatchAlarm = s_r.mcAlarm;
   assign irq = |(s_r.irqStat & s_r.irqEn);
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.rdat;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_REL_NEEDS_RUN_GATE: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(brakeReleaseOut) |-> $past(drive.runCmd && drive.outputGate))
      else $error("release rose without run and gate");

   AST_REL_NEEDS_CURRENT: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(brakeReleaseOut) && $past(s_r.mode == MODE_CURRENT) |-> $past(curScaled >= curLimit))
      else $error("mode 2 release without current");

   AST_SHUTDOWN_DROPS: assert property (@(posedge mclk) disable iff (!rst_b)
      brakeReleaseOut && drive.outputShutdown |=> !brakeReleaseOut)
      else $error("release held through shutdown");

   AST_LOCKOUT: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(brakeReleaseOut) && $past(drive.runCmd) ##1 drive.runCmd |-> !brakeReleaseOut)
      else $error("release returned before run went off");

   AST_ROUTE_OUT0: assert property (@(posedge mclk) disable iff (!rst_b)
      (selOut0 == FN_BRAKE_OUT) && $stable(selOut0) |-> termOut[0] == brakeReleaseOut)
      else $error("terminal 0 does not follow release");

   AST_BUS_ACK_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// ===== src/brs_check.sv
// brs_check: compares a command with its confirmation after a grace window
`timescale 1ns/1ns
`default_nettype none
module brs_check
   import brs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic tick,
   input wire logic enable,
   input wire logic cmd,
   input wire logic fb,
   input wire logic [WIN_W-1:0] window,
   output logic fault
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cmdLast;            // command seen last cycle
      logic [WIN_W-1:0] cnt;    // units since last change
   } brs_chk_s;

   brs_chk_s s_r;
   brs_chk_s s_nxt;
   logic expired;

   // restart the window on each command edge, saturate at window
   always_comb begin
      s_nxt = s_r;
      s_nxt.cmdLast = cmd;
      if (!enable || (cmd != s_r.cmdLast)) begin
         s_nxt.cnt = '0;
      end else if (tick && (s_r.cnt < window)) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // mismatch only counts once the window has run out
   assign expired = (cmd == s_r.cmdLast) && (s_r.cnt >= window);
   assign fault = enable && expired && (cmd != fb);

   AST_CHK_GRACE: assert property (@(posedge mclk) disable iff (!rst_b)
      (cmd != $past(cmd)) && (window != '0) |-> !fault)
      else $error("mismatch flagged inside the window");

   AST_CHK_CAUSE: assert property (@(posedge mclk) disable iff (!rst_b)
      fault |-> enable && (cmd != fb))
      else $error("fault without enabled mismatch");

endmodule
`default_nettype wire

// ===== src/brs_delay.sv
// brs_delay: tick-based delay that reports done once armed long enough
`timescale 1ns/1ns
`default_nettype none
module brs_delay
   import brs_pkg::*;
#(
   parameter int W = 10
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic tick,
   input wire logic arm,
   input wire logic [W-1:0] limit,
   output logic done
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] cnt;   // elapsed units while armed
   } brs_dly_s;

   brs_dly_s s_r;
   brs_dly_s s_nxt;

   // count only while armed continuously, restart on any drop
   always_comb begin
      s_nxt = s_r;
      if (!arm) begin
         s_nxt.cnt = '0;
      end else if (tick && (s_r.cnt < limit)) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // done while armed and the full delay has run
   assign done = arm && (s_r.cnt >= limit);

   AST_DLY_NOT_EARLY: assert property (@(posedge mclk) disable iff (!rst_b)
      arm && !$past(arm) && (limit != '0) |-> !done)
      else $error("delay done on first armed cycle");

   AST_DLY_HOLDS: assert property (@(posedge mclk) disable iff (!rst_b)
      done && $stable(limit) ##1 arm && $stable(limit) |-> done)
      else $error("delay done lost while still armed");

endmodule
`default_nettype wire

// ===== src/brs_pkg.sv
// brs_pkg: constants, offsets and carrier types for the brake release sequencer
package brs_pkg;

   // ----------------------------------------------------------------
   // clocking and setting units
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;                      // mclk period
   localparam int unsigned TICK_NS = 10_000_000;                     // 0.01 s setting unit
   localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;    // cycles per unit
   localparam int TICK_W = 17;                                       // prescaler width

   // ----------------------------------------------------------------
   // setting widths and limits (in 0.01 s or percent)
   // ----------------------------------------------------------------
   localparam int ON_W = 10;
   localparam int OFF_W = 14;
   localparam int WIN_W = 10;
   localparam logic [9:0] ON_MAX = 10'h3e8;      // 10.00 s
   localparam logic [13:0] OFF_MAX = 14'h2710;   // 100.00 s
   localparam logic [9:0] WIN_MAX = 10'h3e8;     // 10.00 s
   localparam logic [7:0] PCT_MAX = 8'hc8;       // 200 %

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;      // mode, alarm reset strobe
   localparam logic [7:0] OFS_THRESH = 8'h04;    // current threshold percent
   localparam logic [7:0] OFS_ONDLY = 8'h08;     // release on-delay
   localparam logic [7:0] OFS_OFFDLY = 8'h0c;    // release off-delay
   localparam logic [7:0] OFS_CHKWIN = 8'h10;    // feedback check window
   localparam logic [7:0] OFS_TERMSEL = 8'h14;   // terminal function selectors
   localparam logic [7:0] OFS_STATUS = 8'h18;    // live state, read only
   localparam logic [7:0] OFS_IRQSTAT = 8'h1c;   // sticky events, read only
   localparam logic [7:0] OFS_IRQCLR = 8'h20;    // write one to clear
   localparam logic [7:0] OFS_IRQEN = 8'h24;     // event enables

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_ALMRST_BIT = 8;            // write one: clear alarms
   localparam logic [1:0] MODE_GATE = 2'h1;       // run and gate
   localparam logic [1:0] MODE_CURRENT = 2'h2;    // run, gate and current
   localparam logic [1:0] MODE_RST = 2'h1;
   localparam logic [7:0] PCT_RST = 8'h00;
   localparam logic [9:0] ONDLY_RST = 10'h000;
   localparam logic [13:0] OFFDLY_RST = 14'h0000;
   localparam logic [9:0] CHKWIN_RST = 10'h000;
   localparam logic [31:0] TERMSEL_RST = 32'h00000000;
   localparam int IRQ_W = 4;
   localparam int IRQ_BRK_TRIP = 0;
   localparam int IRQ_MC_TRIP = 1;
   localparam int IRQ_REL_ON = 2;
   localparam int IRQ_REL_OFF = 3;

   // ----------------------------------------------------------------
   // terminal function codes
   // ----------------------------------------------------------------
   localparam logic [7:0] FN_BRAKE_OUT = 8'h39;   // 57
   localparam logic [7:0] FN_BRAKE_IN = 8'h41;    // 65
   localparam logic [7:0] FN_MC_OUT = 8'h0c;      // 12
   localparam logic [7:0] FN_MC_IN = 8'h67;       // 103

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_APPLIED = 2'b00,
      ST_RELEASED = 2'b01,
      ST_OFF_WAIT = 2'b11,
      ST_LOCKED = 2'b10
   } brs_rel_e;

   // drive-side status that arrives together each cycle
   typedef struct packed {
      logic runCmd;             // run command on
      logic outputGate;         // main output gate on
      logic outputShutdown;     // drive output shut down
      logic belowStopSpeed;     // speed under stop speed
      logic contactorCtrlOut;   // contactor control from the drive
      logic [15:0] outputCurrent;
      logic [15:0] noLoadCurrent;
   } brs_drive_s;

endpackage

// ===== testbench/brs_brake_model.sv
// brs_brake_model: brake with a lagging confirm contact
`timescale 1ns/1ns
`default_nettype none
module brs_brake_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cmd,
   input wire logic stuck,
   output logic confirm
);
   logic [2:0] lagQ;
   // three-cycle contact lag behind the command
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lagQ <= 3'h0;
      end else begin
         lagQ <= {lagQ[1:0], cmd};
      end
   end
   assign confirm = lagQ[2] & ~stuck;
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// tb_top: brake sequencer scenarios
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import brs_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, stuck = 1'b0;
   logic ack, irq, rel, bAlm, mcAlm, tIn0;
   logic [7:0] adr = '0;
   logic [31:0] wdat = '0, rdat;
   logic [1:0] tOut;
   brs_drive_s drv = '0;
   int err_count = 0, n_compared = 0;
   logic [39:0] cfg [6] = '{{OFS_ONDLY, 32'h2}, {OFS_OFFDLY, 32'h3}, {OFS_CHKWIN, 32'h2}, {OFS_THRESH, 32'hff},
      {OFS_IRQEN, 32'h1}, {OFS_TERMSEL, 32'h67410c39}};
   brs_brake_release_sequencer #(.TICK_CYC(4)) dut_u (.mclk(mclk), .rst_b(rst_b), .drive(drv),
      .termIn({tOut[1] & ~stuck, tIn0}), .termOut(tOut), .brakeReleaseOut(rel), .brakeMismatchAlarm(bAlm),
      .contactorMismatchAlarm(mcAlm), .irq(irq), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
   brs_brake_model brk_u (.mclk(mclk), .rst_b(rst_b), .cmd(tOut[0]), .stuck(stuck), .confirm(tIn0));
   initial forever #50 mclk = ~mclk;
   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) err_count++;
      if (got !== exp) $display("[ERR] %s exp %h got %h", nm, exp, got);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do @(posedge mclk); while (ack !== 1'b1);
      {cyc, stb} <= 2'b00;
   endtask
   task automatic waitRel(input logic v);
      for (int i = 0; i < 200 && rel !== v; i++) @(posedge mclk);
      if (rel !== v) err_count++;
      if (rel !== v) $display("[ERR] waitRel exp %h got %h", v, rel);
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic t_release;
      {drv.runCmd, drv.outputGate} <= 2'b11;
      repeat (3) @(posedge mclk);
      chk("early", 32'h0, 32'(rel));
      waitRel(1'b1);
      chk("on", 32'h2, {30'h0, tOut[0] & rel, bAlm});
      stuck <= 1'b1;
      waitRel(1'b0);
      chk("trip", 32'h6, {29'h0, bAlm, irq, rel});
      stuck <= 1'b0;
      bus(1'b1, OFS_CTRL, 32'h101);
      bus(1'b1, OFS_IRQCLR, 32'h1);
      chk("clr", 32'h0, {30'h0, bAlm, irq});
   endtask
   task automatic t_stop;
      drv.runCmd <= 1'b0;
      @(posedge mclk);
      drv.runCmd <= 1'b1;
      waitRel(1'b1);
      drv.belowStopSpeed <= 1'b1;
      waitRel(1'b0);
      drv.belowStopSpeed <= 1'b0;
      repeat (30) @(posedge mclk);
      chk("lock", 32'h0, {30'h0, rel, bAlm});
      bus(1'b0, OFS_STATUS, '0);
      chk("status", 32'h0a, rdat);
   endtask
   task automatic t_mc;
      stuck <= 1'b1;
      drv.contactorCtrlOut <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("mcGrace", 32'h0, 32'(mcAlm));
      repeat (10) @(posedge mclk);
      chk("mcTrip", 32'h1, 32'(mcAlm));
   endtask
   task automatic t_mode2;
      {drv.runCmd, drv.noLoadCurrent, drv.outputCurrent} <= {1'b0, 16'h64, 16'hc7};
      bus(1'b1, OFS_CTRL, 32'(MODE_CURRENT));
      drv.runCmd <= 1'b1;
      repeat (30) @(posedge mclk);
      chk("lowI", 32'h0, 32'(rel));
      drv.outputCurrent <= 16'hc8;
      waitRel(1'b1);
      chk("iOk", 32'h1, 32'(rel));
      drv.outputShutdown <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("shut", 32'h0, 32'(rel));
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      foreach (cfg[i]) bus(1'b1, cfg[i][39:32], cfg[i][31:0]);
      bus(1'b0, 8'h30, '0);
      chk("unmap", 32'h0, rdat);
      bus(1'b0, OFS_THRESH, '0);
      chk("pct", 32'hc8, rdat);
      t_release();
      t_stop();
      t_mode2();
      t_mc();
      conclude();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      err_count++;
      conclude();
   end
endmodule
`default_nettype wire
